// ===== rtl/bfsd_pkg.sv
// constants, types and helpers for the branch and frequency setup execute block
// Functional notes
// - false condition advances program counter by one
// - conditional jumps take 11-bit in-page offset
// - nonzero jump branches when any accumulator bit set
// - zero jump branches when accumulator is zero
// - no-carry jump branches when carry is clear
// - carry jump branches when carry is set
// - paged jump target is page plus offset
// - call pushes next address then jumps paged
// - return reloads last pushed address
// - operand bit six picks generator clock source
// - operand bits four:three pick debounce port
// - operand bits two:zero pick debounce phase
// - register load: accumulator high, memory nibble low
// - indexed load takes preset from table byte
// - immediate load takes preset from operand
// - duty code: quarter, third, half, full
package bfsd_pkg;

  localparam int PC_W    = 12;
  localparam int OFS_W   = 11;
  localparam int NIB_W   = 4;
  localparam int BYTE_W  = 8;
  localparam int DUTY_W  = 2;
  localparam int DBSEL_W = 3;
  localparam int ADDR_W  = 3;
  localparam int PHASE_W = 2;
  localparam int STK_DEPTH = 4;
  localparam int STK_PTR_W = 2;

  localparam logic [PC_W-1:0]   PC_RESET = 12'h000;
  localparam logic [PC_W-1:0]   PC_STEP  = 12'h001;
  localparam logic [NIB_W-1:0]  ACC_ZERO = 4'h0;
  localparam logic [BYTE_W-1:0] FG_CNT_TOP     = 8'hff;
  localparam logic [BYTE_W-1:0] FG_PRESET_RST  = 8'h00;
  localparam logic [DUTY_W-1:0] FG_DUTY_RST    = 2'h0;
  localparam logic [PHASE_W-1:0] PHASE_FIRST   = 2'h0;
  localparam logic [PHASE_W-1:0] PHASE_STEP    = 2'h1;

  // operand field positions of the clock-select instruction
  localparam int CS_FG_SRC_BIT = 6;
  localparam int CS_TGT_HI     = 4;
  localparam int CS_TGT_LO     = 3;
  localparam int CS_CODE_HI    = 2;
  localparam int CS_CODE_LO    = 0;

  localparam logic [1:0] DB_TGT_PORT_D = 2'h1;
  localparam logic [1:0] DB_TGT_PORT_C = 2'h2;
  localparam logic [DBSEL_W-1:0] DB_CODE_PHASE0 = 3'h1;
  localparam logic [DBSEL_W-1:0] DB_CODE_PHASE8 = 3'h2;
  localparam logic [DBSEL_W-1:0] DB_CODE_PHASE6 = 3'h4;

  localparam logic [DUTY_W-1:0] DUTY_QUARTER = 2'h0;
  localparam logic [DUTY_W-1:0] DUTY_THIRD   = 2'h1;
  localparam logic [DUTY_W-1:0] DUTY_HALF    = 2'h2;
  localparam logic [DUTY_W-1:0] DUTY_FULL    = 2'h3;

  // register port map
  localparam logic [ADDR_W-1:0] REG_CTRL   = 3'h0;
  localparam logic [ADDR_W-1:0] REG_PC_LO  = 3'h1;
  localparam logic [ADDR_W-1:0] REG_PC_HI  = 3'h2;
  localparam logic [ADDR_W-1:0] REG_CLKSEL = 3'h3;
  localparam logic [ADDR_W-1:0] REG_PRESET = 3'h4;
  localparam logic [ADDR_W-1:0] REG_DUTY   = 3'h5;
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CLKSEL_FG_BIT  = 7;
  localparam int CLKSEL_D_LO    = 3;
  localparam int PCHI_EMPTY_BIT = 7;
  localparam logic CTRL_RUN_RST = 1'b1;

  typedef enum logic [3:0] {
    OP_NOP         = 4'h0,
    OP_BIT0_TEST   = 4'h1,
    OP_BIT1_TEST   = 4'h2,
    OP_BIT2_TEST   = 4'h3,
    OP_BIT3_TEST   = 4'h4,
    OP_IF_NONZERO  = 4'h5,
    OP_IF_ZERO     = 4'h6,
    OP_IF_NO_CARRY = 4'h7,
    OP_IF_CARRY    = 4'h8,
    OP_PAGED_JUMP  = 4'h9,
    OP_CALL        = 4'ha,
    OP_RET         = 4'hb,
    OP_CLKSEL      = 4'hc,
    OP_FG_REG      = 4'hd,
    OP_FG_TABLE    = 4'he,
    OP_FG_IMM      = 4'hf
  } bfsd_op_t;

  function automatic logic [PC_W-1:0] bfsd_seq_pc(input logic [PC_W-1:0] cur);
    bfsd_seq_pc = cur + PC_STEP;
  endfunction : bfsd_seq_pc

  function automatic logic bfsd_db_code_ok(input logic [DBSEL_W-1:0] code);
    bfsd_db_code_ok = (code == DB_CODE_PHASE0) || (code == DB_CODE_PHASE8) ||
                      (code == DB_CODE_PHASE6);
  endfunction : bfsd_db_code_ok

endpackage : bfsd_pkg

// ===== rtl/bfsd_if.sv
// carriers between the execute top and its generator and stack modules
`timescale 1ns/1ns
interface bfsd_fg_if;
  import bfsd_pkg::*;
  logic              load;
  logic [BYTE_W-1:0] preset;
  logic [DUTY_W-1:0] duty;
  logic              src_wr;
  logic              src_sysclk;
  logic              run;
  logic              out;
  logic              src_sysclk_q;
  logic [BYTE_W-1:0] preset_q;
  logic [DUTY_W-1:0] duty_q;
  modport ctrl (output load, preset, duty, src_wr, src_sysclk, run,
                input  out, src_sysclk_q, preset_q, duty_q);
  modport gen  (input  load, preset, duty, src_wr, src_sysclk, run,
                output out, src_sysclk_q, preset_q, duty_q);
endinterface : bfsd_fg_if

interface bfsd_stk_if;
  import bfsd_pkg::*;
  logic            push;
  logic            pop;
  logic [PC_W-1:0] push_addr;
  logic [PC_W-1:0] top_addr;
  logic            empty;
  modport ctrl (output push, pop, push_addr, input top_addr, empty);
  modport lifo (input push, pop, push_addr, output top_addr, empty);
endinterface : bfsd_stk_if

// ===== rtl/bfsd_freq_gen.sv
// programmable frequency generator with preset, duty code and clock source
`timescale 1ns/1ns
module bfsd_freq_gen
  import bfsd_pkg::*;
(
  // clock and reset
  input wire logic  core_clk,
  input wire logic  sys_rst,
  // prescaler tick
  input wire logic  prescaler_phase_zero,
  // control side
  bfsd_fg_if.gen    fg
);

  logic [BYTE_W-1:0]  cnt;
  logic [PHASE_W-1:0] phase;
  logic               tick;

  function automatic logic [PHASE_W-1:0] last_phase(input logic [DUTY_W-1:0] d);
    case (d)
      DUTY_QUARTER: last_phase = 2'h3;
      DUTY_THIRD:   last_phase = 2'h2;
      DUTY_HALF:    last_phase = 2'h1;
      DUTY_FULL:    last_phase = 2'h0;
      default:      last_phase = 2'h3;
    endcase
  endfunction : last_phase

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      fg.src_sysclk_q <= 1'b0;
    else if (fg.src_wr)
      fg.src_sysclk_q <= fg.src_sysclk;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fg.preset_q <= FG_PRESET_RST;
      fg.duty_q   <= FG_DUTY_RST;
    end else if (fg.load) begin
      fg.preset_q <= fg.preset;
      fg.duty_q   <= fg.duty;
    end
  end

  // system clock source ticks every cycle, otherwise the prescaler pulse
  assign tick = fg.src_sysclk_q | prescaler_phase_zero;

  // counts up from the preset; each overflow advances the duty phase
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt   <= FG_PRESET_RST;
      phase <= PHASE_FIRST;
    end else if (fg.load) begin
      cnt   <= fg.preset;
      phase <= PHASE_FIRST;
    end else if (fg.run && tick) begin
      if (cnt == FG_CNT_TOP) begin
        cnt <= fg.preset_q;
        if (phase >= last_phase(fg.duty_q))
          phase <= PHASE_FIRST;
        else
          phase <= phase + PHASE_STEP;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      fg.out <= 1'b0;
    else
      fg.out <= fg.run && (phase == PHASE_FIRST);
  end

endmodule : bfsd_freq_gen

// ===== rtl/bfsd_stack.sv
// return address stack, oldest entry overwritten when full
`timescale 1ns/1ns
module bfsd_stack
  import bfsd_pkg::*;
(
  // clock and reset
  input wire logic  core_clk,
  input wire logic  sys_rst,
  // control side
  bfsd_stk_if.lifo  stk
);

  logic [PC_W-1:0]      mem [STK_DEPTH];
  logic [STK_PTR_W-1:0] ptr;
  logic [STK_PTR_W:0]   count;

  always_ff @(posedge core_clk) begin
    if (stk.push)
      mem[ptr] <= stk.push_addr;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ptr   <= '0;
      count <= '0;
    end else if (stk.push) begin
      ptr <= ptr + 2'h1;
      if (count != 3'(STK_DEPTH))
        count <= count + 3'h1;
    end else if (stk.pop && (count != '0)) begin
      ptr   <= ptr - 2'h1;
      count <= count - 3'h1;
    end
  end

  assign stk.top_addr = mem[ptr - 2'h1];
  assign stk.empty    = (count == '0);

endmodule : bfsd_stack

// ===== rtl/bfsd_exec.sv
// execute logic for jump, call, return, clock select and generator load
`timescale 1ns/1ns
module bfsd_exec
  import bfsd_pkg::*;
(
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  // decoded instruction
  input  wire logic               instr_valid,
  input  wire bfsd_op_t           instr_op,
  input  wire logic               instr_page,
  input  wire logic [OFS_W-1:0]   instr_offset,
  input  wire logic [BYTE_W-1:0]  instr_operand,
  input  wire logic [DUTY_W-1:0]  instr_duty,
  // core datapath
  input  wire logic [NIB_W-1:0]   accumulator,
  input  wire logic               carry_flag,
  input  wire logic [NIB_W-1:0]   data_mem_nibble,
  input  wire logic [BYTE_W-1:0]  table_rom_data,
  // prescaler ticks
  input  wire logic               prescaler_phase_zero,
  input  wire logic               prescaler_phase_six,
  input  wire logic               prescaler_phase_eight,
  // program counter
  output logic      [PC_W-1:0]    pc,
  // debounce clocks and generator output
  output logic      [DBSEL_W-1:0] port_d_debounce_sel,
  output logic      [DBSEL_W-1:0] port_c_debounce_sel,
  output logic                    port_d_debounce_tick,
  output logic                    port_c_debounce_tick,
  output logic                    freq_out,
  // register port
  input  wire logic [ADDR_W-1:0]  reg_addr,
  input  wire logic [BYTE_W-1:0]  reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [BYTE_W-1:0]  reg_rdata
);

  bfsd_fg_if  fg ();
  bfsd_stk_if stk ();

  logic              take;
  logic [PC_W-1:0]   seq_pc;
  logic [PC_W-1:0]   inpage_pc;
  logic [PC_W-1:0]   paged_pc;
  logic [PC_W-1:0]   next_pc;
  logic              gen_run;
  logic [1:0]        db_tgt;
  logic [DBSEL_W-1:0] db_code;
  logic              is_clksel;

  bfsd_freq_gen u_freq_gen (
    .core_clk             (core_clk),
    .sys_rst              (sys_rst),
    .prescaler_phase_zero (prescaler_phase_zero),
    .fg                   (fg)
  );

  bfsd_stack u_stack (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .stk      (stk)
  );

  function automatic logic phase_tick(input logic [DBSEL_W-1:0] code,
                                      input logic p0, input logic p6,
                                      input logic p8);
    case (code)
      DB_CODE_PHASE0: phase_tick = p0;
      DB_CODE_PHASE8: phase_tick = p8;
      DB_CODE_PHASE6: phase_tick = p6;
      default:        phase_tick = 1'b0;
    endcase
  endfunction : phase_tick

  assign seq_pc    = bfsd_seq_pc(pc);
  assign inpage_pc = {pc[PC_W-1], instr_offset};
  assign paged_pc  = {instr_page, instr_offset};

  // branch condition per opcode
  always_comb begin
    take = 1'b0;
    case (instr_op)
      OP_BIT0_TEST:   take = accumulator[0];
      OP_BIT1_TEST:   take = accumulator[1];
      OP_BIT2_TEST:   take = accumulator[2];
      OP_BIT3_TEST:   take = accumulator[3];
      OP_IF_NONZERO:  take = (accumulator != ACC_ZERO);
      OP_IF_ZERO:     take = (accumulator == ACC_ZERO);
      OP_IF_NO_CARRY: take = ~carry_flag;
      OP_IF_CARRY:    take = carry_flag;
      default:        take = 1'b0;
    endcase
  end

  always_comb begin
    next_pc = seq_pc;
    case (instr_op)
      OP_BIT0_TEST, OP_BIT1_TEST, OP_BIT2_TEST, OP_BIT3_TEST,
      OP_IF_NONZERO, OP_IF_ZERO, OP_IF_NO_CARRY, OP_IF_CARRY: begin
        next_pc = take ? inpage_pc : seq_pc;
      end
      OP_PAGED_JUMP, OP_CALL: begin
        next_pc = paged_pc;
      end
      OP_RET: begin
        next_pc = stk.empty ? seq_pc : stk.top_addr;
      end
      default: next_pc = seq_pc;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      pc <= PC_RESET;
    else if (instr_valid)
      pc <= next_pc;
  end

  assign stk.push      = instr_valid && (instr_op == OP_CALL);
  assign stk.push_addr = seq_pc;
  assign stk.pop       = instr_valid && (instr_op == OP_RET);

  // generator load sources
  assign fg.load = instr_valid &&
                   ((instr_op == OP_FG_REG) || (instr_op == OP_FG_TABLE) ||
                    (instr_op == OP_FG_IMM));
  assign fg.duty = instr_duty;
  always_comb begin
    case (instr_op)
      OP_FG_REG:   fg.preset = {accumulator, data_mem_nibble};
      OP_FG_TABLE: fg.preset = table_rom_data;
      OP_FG_IMM:   fg.preset = instr_operand;
      default:     fg.preset = instr_operand;
    endcase
  end

  assign is_clksel     = instr_valid && (instr_op == OP_CLKSEL);
  assign fg.src_wr     = is_clksel;
  assign fg.src_sysclk = instr_operand[CS_FG_SRC_BIT];
  assign fg.run        = gen_run;
  assign freq_out      = fg.out;

  assign db_tgt  = instr_operand[CS_TGT_HI:CS_TGT_LO];
  assign db_code = instr_operand[CS_CODE_HI:CS_CODE_LO];

  // unlisted phase codes leave the selection alone rather than stop the clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_d_debounce_sel <= DB_CODE_PHASE0;
      port_c_debounce_sel <= DB_CODE_PHASE0;
    end else if (is_clksel && bfsd_db_code_ok(db_code)) begin
      if (db_tgt == DB_TGT_PORT_D)
        port_d_debounce_sel <= db_code;
      else if (db_tgt == DB_TGT_PORT_C)
        port_c_debounce_sel <= db_code;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_d_debounce_tick <= 1'b0;
      port_c_debounce_tick <= 1'b0;
    end else begin
      port_d_debounce_tick <= phase_tick(port_d_debounce_sel, prescaler_phase_zero,
                                         prescaler_phase_six, prescaler_phase_eight);
      port_c_debounce_tick <= phase_tick(port_c_debounce_sel, prescaler_phase_zero,
                                         prescaler_phase_six, prescaler_phase_eight);
    end
  end

  // register port: control write, state readback
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      gen_run <= CTRL_RUN_RST;
    else if (reg_wr && (reg_addr == REG_CTRL))
      gen_run <= reg_wdata[CTRL_RUN_BIT];
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:   reg_rdata <= {7'h00, gen_run};
        REG_PC_LO:  reg_rdata <= pc[7:0];
        REG_PC_HI:  reg_rdata <= {stk.empty, 3'h0, pc[PC_W-1:8]};
        REG_CLKSEL: reg_rdata <= {fg.src_sysclk_q, 1'b0, port_d_debounce_sel,
                                  port_c_debounce_sel};
        REG_PRESET: reg_rdata <= fg.preset_q;
        REG_DUTY:   reg_rdata <= {6'h00, fg.duty_q};
        default:    reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : bfsd_exec

// ===== tb/bfsd_exec_properties.sv
// port assertions for the execute block
`timescale 1ns/1ns
module bfsd_exec_properties
  import bfsd_pkg::*;
(
  // clock
  input wire logic               core_clk,
  input wire logic               sys_rst,
  // inputs
  input wire logic               instr_valid,
  input wire bfsd_op_t           instr_op,
  input wire logic               instr_page,
  input wire logic [OFS_W-1:0]   instr_offset,
  input wire logic [BYTE_W-1:0]  instr_operand,
  input wire logic [NIB_W-1:0]   accumulator,
  input wire logic               carry_flag,
  // outputs
  input wire logic [PC_W-1:0]    pc,
  input wire logic [DBSEL_W-1:0] port_d_debounce_sel,
  input wire logic [DBSEL_W-1:0] port_c_debounce_sel
);
  logic [15:0]        hit;
  logic [7:0]         cond;
  logic [PC_W-1:0]    in_page;
  logic [DBSEL_W-1:0] db_code;
  // one flag per opcode keeps each rule a single bit test
  assign hit     = instr_valid ? (16'h0001 << instr_op) : 16'h0000;
  assign cond    = {carry_flag, !carry_flag, accumulator == ACC_ZERO,
                    accumulator != ACC_ZERO, accumulator};
  assign in_page = {pc[PC_W-1], instr_offset};
  assign db_code = instr_operand[2:0];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_jump(c);
    c |=> pc == $past(in_page);
  endproperty
  sequence s_call_ret;
    hit[OP_CALL] ##1 hit[OP_RET];
  endsequence
  sequence s_sel(tgt);
    hit[OP_CLKSEL] && instr_operand[4:3] == tgt && $onehot(db_code);
  endsequence

  chk_bit_jump: assert property (p_jump(|(hit[4:1] & cond[3:0])))
    else $error("bit test jump wrong");
  chk_acc_jump: assert property (
    p_jump(hit[OP_IF_NONZERO] && cond[4] || hit[OP_IF_ZERO] && cond[5]))
    else $error("accumulator jump wrong");
  chk_carry_jump: assert property (
    p_jump(hit[OP_IF_NO_CARRY] && cond[6] || hit[OP_IF_CARRY] && cond[7]))
    else $error("carry jump wrong");
  chk_cond_fall: assert property (
    |(hit[8:1] & ~cond) |=> pc == $past(pc) + PC_STEP)
    else $error("fall through wrong");
  chk_paged_jump: assert property (
    hit[OP_PAGED_JUMP] || hit[OP_CALL] |=> pc == {$past(instr_page), $past(instr_offset)})
    else $error("paged target wrong");
  chk_call_return: assert property (
    s_call_ret |=> pc == $past(pc, 2) + PC_STEP)
    else $error("return address wrong");
  chk_port_d_sel: assert property (
    s_sel(DB_TGT_PORT_D) |=> port_d_debounce_sel == $past(db_code))
    else $error("port d select wrong");
  chk_port_c_sel: assert property (
    s_sel(DB_TGT_PORT_C) |=> port_c_debounce_sel == $past(db_code))
    else $error("port c select wrong");
  chk_sel_refused: assert property (
    hit[OP_CLKSEL] && !$onehot(db_code) |=>
    $stable(port_d_debounce_sel) && $stable(port_c_debounce_sel))
    else $error("refused select changed");
endmodule : bfsd_exec_properties

bind bfsd_exec bfsd_exec_properties chk_u (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .instr_valid(instr_valid),
  .instr_op(instr_op),
  .instr_page(instr_page),
  .instr_offset(instr_offset),
  .instr_operand(instr_operand),
  .accumulator(accumulator),
  .carry_flag(carry_flag),
  .pc(pc),
  .port_d_debounce_sel(port_d_debounce_sel),
  .port_c_debounce_sel(port_c_debounce_sel)
);

// ===== tb/bfsd_exec_tb.sv
// self-checking bench for the execute block
`timescale 1ns/1ns
module bfsd_exec_tb;
  import bfsd_pkg::*;
  logic              core_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              instr_valid = 1'b0;
  bfsd_op_t          instr_op = OP_NOP;
  logic              instr_page = 1'b0;
  logic [OFS_W-1:0]  instr_offset = 11'h000;
  logic [BYTE_W-1:0] instr_operand = 8'h00;
  logic [DUTY_W-1:0] instr_duty = 2'h0;
  logic [NIB_W-1:0]  accumulator = 4'h0;
  logic              carry_flag = 1'b0;
  logic [NIB_W-1:0]  data_mem_nibble = 4'h0;
  logic [BYTE_W-1:0] table_rom_data = 8'h00;
  logic [3:0]        pre_cnt = 4'h0;
  logic [2:0]        ph = 3'h0;
  logic [ADDR_W-1:0] reg_addr = 3'h0;
  logic [BYTE_W-1:0] reg_wdata = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [BYTE_W-1:0] reg_rdata;
  logic [PC_W-1:0]   pc;
  logic              d_tick;
  logic              c_tick;
  logic              freq_out;
  logic [2:0]        exp_d = 3'h1;
  logic [2:0]        exp_c = 3'h1;
  logic [7:0]        x;
  logic [3:0]        acc_t [8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1, 4'h0, 4'h0, 4'h0};
  logic [3:0]        acc_f [8] = '{4'he, 4'hd, 4'hb, 4'h7, 4'h0, 4'hf, 4'h0, 4'h0};
  logic [7:0]        sel_x [8] = '{8'h09, 8'h4a, 8'h51, 8'h54, 8'h0c, 8'h12, 8'h4b, 8'h1c};
  int                num_errors = 0;
  int                checks = 0;
  int                n, nd, nc, e;

  always #50 core_clk = ~core_clk;
  // stand-in prescaler: phase zero every 4 cycles, six and eight every 16
  always @(posedge core_clk) begin
    pre_cnt <= pre_cnt + 4'h1;
    ph      <= {pre_cnt == 4'h8, pre_cnt == 4'h6, pre_cnt[1:0] == 2'h0};
  end

  bfsd_exec dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_page(instr_page), .instr_offset(instr_offset),
    .instr_operand(instr_operand), .instr_duty(instr_duty),
    .accumulator(accumulator), .carry_flag(carry_flag),
    .data_mem_nibble(data_mem_nibble), .table_rom_data(table_rom_data),
    .prescaler_phase_zero(ph[0]), .prescaler_phase_six(ph[1]),
    .prescaler_phase_eight(ph[2]), .pc(pc),
    .port_d_debounce_sel(), .port_c_debounce_sel(),
    .port_d_debounce_tick(d_tick), .port_c_debounce_tick(c_tick),
    .freq_out(freq_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // duty rides on t, carry on x bit 0; table data is inverted so forms differ
  task automatic run(input bfsd_op_t o, input logic [11:0] t, input logic [7:0] x);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_op <= o;
    {instr_page, instr_offset} <= t;
    instr_duty <= t[1:0];
    instr_operand <= x;
    table_rom_data <= ~x;
    accumulator <= x[7:4];
    data_mem_nibble <= x[3:0] ^ 4'h5;
    carry_flag <= x[0];
  endtask : run

  task automatic idle;
    @(posedge core_clk);
    instr_valid <= 1'b0;
    #1;
  endtask : idle

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk({4'h0, reg_rdata}, {4'h0, v});
  endtask : rdc

  task automatic count_hi(input int cyc);
    n = 0;
    nd = 0;
    nc = 0;
    repeat (cyc) begin
      @(posedge core_clk);
      #1;
      n += (freq_out === 1'b1);
      nd += (d_tick === 1'b1);
      nc += (c_tick === 1'b1);
    end
  endtask : count_hi

  task automatic stop_test;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    #3_000_000;
    num_errors++;
    $display("Error at %0t: timeout", $time);
    stop_test;
  end

  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk(pc, PC_RESET);
    rdc(REG_CTRL, 8'h01);
    rdc(REG_PC_HI, 8'h80);
    run(OP_PAGED_JUMP, 12'h7ff, 8'h00);
    idle;
    chk(pc, 12'h7ff);
    run(OP_PAGED_JUMP, 12'hbff, 8'h00);
    idle;
    chk(pc, 12'hbff);
    for (int k = 0; k < 8; k++) begin
      for (int v = 0; v < 2; v++) begin
        run(OP_PAGED_JUMP, 12'h805, 8'h00);
        run(bfsd_op_t'(k + 1), 12'h123, {v ? acc_t[k] : acc_f[k], 3'h0, v ? k == 7 : k == 6});
        idle;
        chk(pc, v ? 12'h923 : 12'h806);
      end
    end
    run(OP_BIT3_TEST, 12'h7ff, 8'h80);
    idle;
    chk(pc, 12'hfff);
    run(OP_PAGED_JUMP, 12'h005, 8'h00);
    run(OP_CALL, 12'h810, 8'h00);
    idle;
    chk(pc, 12'h810);
    rdc(REG_PC_HI, 8'h08);
    run(OP_CALL, 12'h020, 8'h00);
    run(OP_RET, 12'h000, 8'h00);
    idle;
    chk(pc, 12'h811);
    run(OP_RET, 12'h000, 8'h00);
    idle;
    chk(pc, 12'h006);
    rdc(REG_PC_HI, 8'h80);
    wr(REG_PC_LO, 8'h55);
    rdc(REG_PC_LO, 8'h06);
    wr(3'h6, 8'hff);
    rdc(3'h6, 8'h00);
    foreach (sel_x[i]) begin
      x = sel_x[i];
      if ($onehot(x[2:0]) && x[4:3] == DB_TGT_PORT_D)
        exp_d = x[2:0];
      if ($onehot(x[2:0]) && x[4:3] == DB_TGT_PORT_C)
        exp_c = x[2:0];
      run(OP_CLKSEL, 12'h000, x);
      idle;
      rdc(REG_CLKSEL, {x[6], 1'b0, exp_d, exp_c});
    end
    count_hi(32);
    chk(12'(nd), 12'h002);
    chk(12'(nc), 12'h002);
    // port d back to phase zero: four times the ticks of phase six
    run(OP_CLKSEL, 12'h000, 8'h09);
    idle;
    count_hi(32);
    chk(12'(nd), 12'h008);
    chk(12'(nc), 12'h002);
    run(OP_FG_REG, 12'h001, 8'ha0);
    idle;
    rdc(REG_PRESET, 8'ha5);
    rdc(REG_DUTY, 8'h01);
    run(OP_FG_TABLE, 12'h002, 8'hc3);
    idle;
    rdc(REG_PRESET, 8'h3c);
    run(OP_FG_IMM, 12'h003, 8'hc3);
    idle;
    rdc(REG_PRESET, 8'hc3);
    rdc(REG_DUTY, 8'h03);
    run(OP_CLKSEL, 12'h000, 8'h40);
    for (int d = 0; d < 4; d++) begin
      run(OP_FG_IMM, 12'(d), 8'hff);
      idle;
      count_hi(8);
      count_hi(24);
      e = 24 / (4 - d);
      chk(12'(n >= e - 1 && n <= e + 1), 12'h001);
    end
    wr(REG_CTRL, 8'h00);
    rdc(REG_CTRL, 8'h00);
    count_hi(24);
    chk(12'(n), 12'h000);
    wr(REG_CTRL, 8'h01);
    stop_test;
  end
endmodule : bfsd_exec_tb
